//--- seq_step_cfg.sv
// Step-twelve configuration register with Avalon-MM slave access.
// Assumes the sequencer engine pulses STEP_SELECT_IN on this clock
// when it reaches step twelve; one-cycle waitrequest on every access.
`timescale 1ns/1ps
`default_nettype none
`include "seq_step_defs.svh"
module seq_step_cfg
   import seq_step_pkg::*;
(
   input  wire logic        CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic [7:0]  AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   input  wire logic [3:0]  AVS_BYTEENABLE_IN,
   output logic [31:0]      AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   input  wire logic        STEP_SELECT_IN,
   output logic             STEP_ACTIVE_OUT,
   output logic             STEP_SKIP_OUT,
   output route_s           ROUTE_OUT
);

   top_state_s s;
   top_state_s next_s;
   route_s     decoded;
   logic       req;
   logic       hit_cfg;
   logic       hit_stat;
   logic [15:0] wval;

   ////////////////////////////////////////////////////////////////////
   // Decode

   step_route_decode u_decode
   (
      .cfg_in    (s.cfg),
      .route_out (decoded)
   );

   assign req      = AVS_READ_IN | AVS_WRITE_IN;
   assign hit_cfg  = AVS_ADDRESS_IN == `SEQ_CFG_ADDR;
   assign hit_stat = AVS_ADDRESS_IN == `SEQ_STAT_ADDR;

   // First cycle of a request always waits; registered read data
   // is then ready when waitrequest drops.
   assign AVS_WAITREQUEST_OUT = req & ~s.ack;
   assign AVS_READDATA_OUT    = s.rdata;
   assign STEP_ACTIVE_OUT     = s.active;
   assign STEP_SKIP_OUT       = s.skip;
   assign ROUTE_OUT           = s.route;

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_s = s;
      wval   = s.cfg;
      next_s.ack    = req & ~s.ack;
      next_s.active = 1'b0;
      next_s.skip   = 1'b0;

      if (AVS_READ_IN && !s.ack)
      begin
         if (hit_cfg)
         begin
            next_s.rdata = {16'h0000, s.cfg};                 // [R7]
         end
         else if (hit_stat)
         begin
            next_s.rdata = {16'h0000, s.run_cnt, s.skip_cnt};
         end
         else
         begin
            next_s.rdata = 32'h00000000;
         end
      end

      // Write lands at the edge where waitrequest is low
      if (AVS_WRITE_IN && s.ack && hit_cfg)
      begin
         if (AVS_BYTEENABLE_IN[0])
         begin
            wval[7:0] = AVS_WRITEDATA_IN[7:0];
         end
         if (AVS_BYTEENABLE_IN[1])
         begin
            wval[15:8] = AVS_WRITEDATA_IN[15:8];
         end
         // Reserved bits 12:5 never store, so they read as zero
         next_s.cfg = cfg_s'(wval & `SEQ_CFG_WMASK);          // [R7]
      end

      // Only an enabled step touches the front-end selects; a
      // disabled one leaves the previous step's routing in place.
      if (STEP_SELECT_IN)
      begin
         if (s.cfg.seq_step_enable_bit)                        // [R1]
         begin
            next_s.active  = 1'b1;                             // [R8]
            next_s.route   = decoded;                          // [R8]
            next_s.run_cnt = s.run_cnt + 8'h01;
         end
         else
         begin
            next_s.skip     = 1'b1;                            // [R8]
            next_s.skip_cnt = s.skip_cnt + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         s.cfg      <= cfg_s'(`SEQ_CFG_RESET);                 // [R7]
         s.ack      <= 1'b0;
         s.rdata    <= 32'h00000000;
         s.route    <= route_s'(8'h00);
         s.active   <= 1'b0;
         s.skip     <= 1'b0;
         s.run_cnt  <= `SEQ_CNT_RESET;
         s.skip_cnt <= `SEQ_CNT_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   sequence s_sel_on;
      STEP_SELECT_IN && s.cfg.seq_step_enable_bit;
   endsequence

   sequence s_sel_off;
      STEP_SELECT_IN && !s.cfg.seq_step_enable_bit;
   endsequence

   sequence s_wait_then_go;
      req && AVS_WAITREQUEST_OUT ##1 req && !AVS_WAITREQUEST_OUT;
   endsequence

   property p_enable;
      s_sel_on |=> STEP_ACTIVE_OUT && !STEP_SKIP_OUT;
   endproperty
   a_enable: assert property (p_enable) // [R1]
      else $error("enabled step did not activate");

   property p_gain;
      STEP_ACTIVE_OUT |->
         (ROUTE_OUT.gain == GAIN_X1) ==
            ($past(s.cfg.seq_step_gain_sel) == 2'h0) &&
         (ROUTE_OUT.gain == GAIN_X2) ==
            ($past(s.cfg.seq_step_gain_sel) == 2'h1);
   endproperty
   a_gain: assert property (p_gain) // [R2]
      else $error("gain does not follow the gain field");

   property p_neg;
      s_sel_on ##0 !s.cfg.seq_step_pos_input_sel[`SEQ_AUTO_BIT]
         |=> ROUTE_OUT.neg == ($past(s.cfg.seq_step_neg_input_sel)
                               ? NEG_INPUT_SEVEN : NEG_GROUND);
   endproperty
   a_neg: assert property (p_neg) // [R3]
      else $error("negative input does not follow its bit");

   property p_pos;
      s_sel_on |=> ROUTE_OUT.pos == $past(s.cfg.seq_step_pos_input_sel);
   endproperty
   a_pos: assert property (p_pos) // [R4]
      else $error("positive input does not follow its code");

   property p_auto;
      s_sel_on ##0 s.cfg.seq_step_pos_input_sel[`SEQ_AUTO_BIT]
         |=> ROUTE_OUT.neg == NEG_AUTO;
   endproperty
   a_auto: assert property (p_auto) // [R5]
      else $error("internal source without automatic pairing");

   property p_neg_ignored;
      STEP_ACTIVE_OUT && ROUTE_OUT.pos[`SEQ_AUTO_BIT]
         |-> ROUTE_OUT.neg != NEG_INPUT_SEVEN
             && ROUTE_OUT.neg != NEG_GROUND;
   endproperty
   a_neg_ignored: assert property (p_neg_ignored) // [R6]
      else $error("negative select bit used on auto source");

   property p_readback;
      s_wait_then_go ##0 AVS_READ_IN && hit_cfg
         |-> AVS_READDATA_OUT == {16'h0000, s.cfg}
             && AVS_READDATA_OUT[12:5] == 8'h00;
   endproperty
   a_readback: assert property (p_readback) // [R7]
      else $error("configuration readback mismatch");

   property p_wait;
      req && !s.ack |-> AVS_WAITREQUEST_OUT ##1
         (!req || !AVS_WAITREQUEST_OUT);
   endproperty
   a_wait: assert property (p_wait) // [R7]
      else $error("waitrequest did not drop after one cycle");

   property p_skip;
      s_sel_off |=> STEP_SKIP_OUT && !STEP_ACTIVE_OUT
                    && $stable(ROUTE_OUT);
   endproperty
   a_skip: assert property (p_skip) // [R8]
      else $error("disabled step changed routing");

endmodule
`default_nettype wire

//--- seq_step_defs.svh
// Constants for the step-twelve sequencer configuration register.
// Assumes Avalon-MM byte addressing with 32-bit data words.
//
// Functional notes
// [R1] Bit 15 enables step twelve in sequence
// [R2] Bits 14:13 gain: 0=x1, 1=x2, 2/3=x4
// [R3] Bit 4 negative: 0 ground, 1 input seven
// [R4] Bits 3:0 codes 0-7 pick inputs 0-7
// [R5] Codes 8-15 internal sources, negative paired automatically
// [R6] Auto-paired codes ignore the negative select bit
// [R7] Register at 9Ch, resets to 000Ch
// [R8] Disabled step is skipped, enabled step applies selections
`ifndef SEQ_STEP_DEFS_SVH
`define SEQ_STEP_DEFS_SVH

`define SEQ_CFG_ADDR   8'h9C
`define SEQ_STAT_ADDR  8'hA0
`define SEQ_CFG_RESET  16'h000C
`define SEQ_CFG_WMASK  16'hE01F
`define SEQ_EN_BIT     15
`define SEQ_GAIN_HI    14
`define SEQ_GAIN_LO    13
`define SEQ_NEG_BIT    4
`define SEQ_POS_HI     3
`define SEQ_POS_LO     0
`define SEQ_AUTO_BIT   3
`define SEQ_CNT_RESET  8'h00

`endif

//--- seq_step_pkg.sv
// Types shared by the step-twelve configuration block.
// Assumes seq_step_defs.svh supplies the numeric constants.
`default_nettype none
package seq_step_pkg;

   typedef enum logic [1:0] {GAIN_X1, GAIN_X2, GAIN_X4} gain_e;

   typedef enum logic [1:0]
   {
      NEG_GROUND,
      NEG_INPUT_SEVEN,
      NEG_AUTO
   } neg_src_e;

   // Field layout of the 16-bit configuration word
   typedef struct packed
   {
      logic       seq_step_enable_bit;
      logic [1:0] seq_step_gain_sel;
      logic [7:0] rsvd;
      logic       seq_step_neg_input_sel;
      logic [3:0] seq_step_pos_input_sel;
   } cfg_s;

   // Selections handed to the converter front end
   typedef struct packed
   {
      logic [3:0] pos;
      neg_src_e   neg;
      gain_e      gain;
   } route_s;

   typedef struct packed
   {
      cfg_s        cfg;
      logic        ack;
      logic [31:0] rdata;
      route_s      route;
      logic        active;
      logic        skip;
      logic [7:0]  run_cnt;
      logic [7:0]  skip_cnt;
   } top_state_s;

endpackage
`default_nettype wire

//--- step_route_decode.sv
// Decoder from configuration word to converter input and gain selects.
// Purely combinational; assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "seq_step_defs.svh"
module step_route_decode
   import seq_step_pkg::*;
(
   input  wire cfg_s   cfg_in,
   output route_s      route_out
);

   always_comb
   begin
      route_out.pos = cfg_in.seq_step_pos_input_sel;          // [R4]
      unique case (cfg_in.seq_step_gain_sel)                  // [R2]
         2'h0: route_out.gain = GAIN_X1;
         2'h1: route_out.gain = GAIN_X2;
         2'h2: route_out.gain = GAIN_X4;
         2'h3: route_out.gain = GAIN_X4;
      endcase
      // Internal sources carry their own return path
      if (cfg_in.seq_step_pos_input_sel[`SEQ_AUTO_BIT])
      begin
         route_out.neg = NEG_AUTO;                            // [R5] [R6]
      end
      else if (cfg_in.seq_step_neg_input_sel)
      begin
         route_out.neg = NEG_INPUT_SEVEN;                     // [R3]
      end
      else
      begin
         route_out.neg = NEG_GROUND;                          // [R3]
      end
   end

endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the step-twelve configuration register.
// Assumes seq_step_cfg carries its own assertions; bench drives all ports.
`timescale 1ns/1ps
`default_nettype none
module tb
   import seq_step_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        rd;
   logic        wr;
   logic        sel;
   logic        wq;
   logic        act;
   logic        skp;
   logic [7:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   route_s      route;
   route_s      exp_route;
   int          mismatches;
   int          checks;
   logic [7:0]  runs;
   logic [7:0]  skips;

   seq_step_cfg dut_u (
      .CLK_IN             (clk),
      .RST_IN             (rst),
      .AVS_ADDRESS_IN     (addr),
      .AVS_READ_IN        (rd),
      .AVS_WRITE_IN       (wr),
      .AVS_WRITEDATA_IN   (wdata),
      .AVS_BYTEENABLE_IN  (be),
      .AVS_READDATA_OUT   (rdata),
      .AVS_WAITREQUEST_OUT(wq),
      .STEP_SELECT_IN     (sel),
      .STEP_ACTIVE_OUT    (act),
      .STEP_SKIP_OUT      (skp),
      .ROUTE_OUT          (route)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Waits on waitrequest, then checks that it dropped after exactly one cycle
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      be    <= b;
      wr    <= w;
      rd    <= !w;
      // Waitrequest and read data are judged as they stand at each edge
      @(posedge clk);
      while (wq !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         mismatches++;
      chk(n, 32'h00000001);
      rd_val = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic step(input logic en);
      @(posedge clk);
      sel <= 1'b1;
      @(posedge clk);
      sel <= 1'b0;
      @(negedge clk);
      chk(act, en);
      chk(skp, !en);
      chk(route, exp_route);
      @(negedge clk);
      chk({act, skp}, 2'b00);
   endtask

   // Expected selections worked out from the field encodings
   function automatic route_s exp_of(input logic [15:0] c);
      exp_of.pos  = c[3:0];
      exp_of.neg  = c[3] ? NEG_AUTO : (c[4] ? NEG_INPUT_SEVEN : NEG_GROUND);
      exp_of.gain = (c[14:13] == 2'h0) ? GAIN_X1 :
                    (c[14:13] == 2'h1) ? GAIN_X2 : GAIN_X4;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      bus(1'b0, 8'h9C, 32'h0, 4'hF);
      chk(rd_val, 32'h0000000C);
      bus(1'b0, 8'hA0, 32'h0, 4'hF);
      chk(rd_val, 32'h00000000);
      chk(route, 8'h00);
   endtask

   // Every gain code, every positive code, both negative settings
   task automatic t_routes();
      logic [15:0] c;
      for (int g = 0; g < 4; g++)
         for (int p = 0; p < 16; p++)
            for (int n = 0; n < 2; n++)
            begin
               c = {1'b1, 2'(g), 8'h00, 1'(n), 4'(p)};
               bus(1'b1, 8'h9C, {16'hFFFF, c}, 4'hF);
               bus(1'b0, 8'h9C, 32'h0, 4'hF);
               chk(rd_val, {16'h0000, c});
               exp_route = exp_of(c);
               step(1'b1);
               runs++;
            end
   endtask

   // Disabled step leaves the front end on its last selection
   task automatic t_skip();
      bus(1'b1, 8'h9C, 32'h00002013, 4'hF);
      step(1'b0);
      skips++;
      step(1'b0);
      skips++;
   endtask

   task automatic t_refuse();
      bus(1'b1, 8'h9C, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 8'h9C, 32'h0, 4'hF);
      chk(rd_val, 32'h0000E01F);
      bus(1'b1, 8'h9C, 32'h00000000, 4'h1);
      bus(1'b0, 8'h9C, 32'h0, 4'hF);
      chk(rd_val, 32'h0000E000);
      bus(1'b1, 8'h10, 32'h0000FFFF, 4'hF);
      bus(1'b0, 8'h10, 32'h0, 4'hF);
      chk(rd_val, 32'h00000000);
      bus(1'b0, 8'h9C, 32'h0, 4'hF);
      chk(rd_val, 32'h0000E000);
      bus(1'b1, 8'hA0, 32'h0000FFFF, 4'hF);
      bus(1'b0, 8'hA0, 32'h0, 4'hF);
      chk(rd_val, {16'h0000, runs, skips});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      // Generous bound: the full sweep needs about 1300 cycles
      #400000;
      mismatches++;
      results();
   end

   initial
   begin
      mismatches = 0;
      checks     = 0;
      runs       = 8'h00;
      skips      = 8'h00;
      rst        = 1'b1;
      rd         = 1'b0;
      wr         = 1'b0;
      sel        = 1'b0;
      addr       = 8'h00;
      be         = 4'h0;
      wdata      = 32'h0;
      exp_route  = route_s'(8'h00);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_routes();
      t_skip();
      t_refuse();
      results();
   end
endmodule
`default_nettype wire
